// ---- hw/timer_pkg.sv ----
package timer_pkg;

  // Register byte addresses on the APB.
  localparam logic [7:0] ADDR_PRESCALE = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_COUNTER_ONE = 8'h08;
  localparam logic [7:0] ADDR_COUNTER_TWO = 8'h0c;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE_A = 8'h10;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE_B = 8'h14;
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_INT_CONTROL = 8'h1c;
  localparam logic [7:0] ADDR_INT_CLEAR = 8'h20;

  // Field positions in the clock control register.
  localparam int CLOCK_ONE_LSB = 0;
  localparam int CLOCK_TWO_LSB = 3;

  // Field positions in the mode control register.
  localparam int MODE_LSB = 0;
  localparam int EDGE_A_BIT = 2;
  localparam int EDGE_B_BIT = 3;
  localparam int PIN_A_ENABLE_BIT = 4;
  localparam int PRESET_B_BIT = 5;
  localparam int PIN_A_LEVEL_BIT = 6;

  // Field positions in the interrupt control register.
  localparam int INT_ENABLE_LSB = 0;
  localparam int INT_PENDING_LSB = 4;

  // Interrupt source indices.
  localparam int SRC_A = 0;
  localparam int SRC_B = 1;
  localparam int SRC_C = 2;
  localparam int SRC_D = 3;

  // Operating modes.
  localparam logic [1:0] MODE_PWM_TIMER = 2'h0;
  localparam logic [1:0] MODE_DUAL_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_DUAL_TIMER = 2'h2;
  localparam logic [1:0] MODE_SINGLE_CAPTURE = 2'h3;

  // Counter clock selections.
  localparam logic [2:0] CLK_STOPPED = 3'h0;
  localparam logic [2:0] CLK_PRESCALED = 3'h1;
  localparam logic [2:0] CLK_EXT_EVENT = 3'h2;
  localparam logic [2:0] CLK_PULSE_ACC = 3'h3;
  localparam logic [2:0] CLK_SLOW = 3'h4;

  // Values after reset and the capture preset.
  localparam logic [4:0] PRESCALE_RESET = 5'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PRESET_VALUE = 16'hffff;
  localparam logic [3:0] INT_RESET = 4'h0;

endpackage

// ---- hw/dual_counter_capture_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Function
// - Dual-capture mode: counter one counts on its selected clock; both pins capture.
// - Edge on pin A copies counter one to capture A; pin B to capture B.
// - Each capture input has its own rising or falling edge choice.
// - With preset enabled (pin A output enable bit for A, preset bit for B), capture stores counter first, then loads counter with all ones.
// - Dual-capture raises pin A, pin B and counter one underflow events, each enabled.
// - Dual-capture: counter two is a plain down timer; underflow pends source D.
// - Capture modes: external-event or pulse-accumulate selection stops the counter.
// - Dual-timer and single-capture: counter one reloads from capture A on underflow.
// - Pin A output enabled: pin A inverts on every counter one underflow outside dual-capture.
// - Timer modes: low-to-high pin A toggle sets source C pending, gated by A enable.
// - Dual-timer: pin B clocks either counter as event or pulse-accumulate input.
// - Dual-timer: counter two reloads from capture B on underflow and pends source D.
// - Single-capture: selected edge on pin B copies counter two to capture B.
// - Single-capture with preset: store counter two, then load it with all ones.
// - Single-capture raises pin B capture and counter two underflow events, each enabled.
// - Sources A, B, C feed interrupt one; source D alone feeds interrupt two.
// - Interrupt one drives request line 14, interrupt two request line 13.
// - Two-bit mode field selects PWM, dual-capture, dual-timer or single-capture mode.
// - Clock select: stopped, prescaled, external event, pulse-accumulate, slow; others reserved.
// - Pin A starts toggling from the initial level bit set before the clock starts.
module dual_counter_capture_timer
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_io_a_in,
  output logic timer_io_a_out,
  output logic timer_io_a_oe,
  input wire logic timer_io_b_in,
  input wire logic slow_clock_in,
  output logic irq_line_14,
  output logic irq_line_13
);
  import timer_pkg::*;

  typedef struct packed {
    logic [2:0] sync_a;
    logic stable_a;
    logic [2:0] sync_b;
    logic stable_b;
    logic [2:0] sync_slow;
    logic stable_slow;
    logic [4:0] prescale;
    logic [4:0] prescale_count;
    logic [2:0] clock_one;
    logic [2:0] clock_two;
    logic [15:0] counter_one;
    logic [15:0] counter_two;
    logic [15:0] reload_capture_a;
    logic [15:0] reload_capture_b;
    logic [1:0] mode_select;
    logic edge_a;
    logic edge_b;
    logic pin_a_output_enable;
    logic preset_b;
    logic pin_a_initial_level;
    logic [3:0] int_enable;
    logic [3:0] pending;
    logic pin_a_level;
    logic [31:0] read_data;
  } state_t;

  state_t q;
  state_t next_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // A settled change: the second and third stages agree on a new level.
  function automatic logic settled_change(input logic [2:0] sync, input logic stable);
    settled_change = (sync[1] == sync[2]) && (sync[2] != stable);
  endfunction

  // Count enable of one counter from its clock selection.
  function automatic logic count_tick(input logic [2:0] sel, input logic capture_mode,
                                      input logic prescaled, input logic ext_event,
                                      input logic accumulate, input logic slow);
    unique case (sel)
      CLK_PRESCALED: count_tick = prescaled;
      CLK_EXT_EVENT: count_tick = !capture_mode && ext_event;
      CLK_PULSE_ACC: count_tick = !capture_mode && prescaled && accumulate;
      CLK_SLOW: count_tick = slow;
      default: count_tick = 1'b0;
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr <= ADDR_INT_CLEAR) && (addr[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational events.

  logic mode_cap2;
  logic mode_cap4;
  logic capture_mode;
  logic change_a;
  logic change_b;
  logic change_slow;
  logic edge_event_a;
  logic edge_event_b;
  logic prescaled_tick;
  logic tick_one;
  logic tick_two;
  logic underflow_one;
  logic underflow_two;
  logic capture_a;
  logic capture_b;
  logic write_access;
  logic setup_access;
  logic wr_counter_one;
  logic wr_counter_two;
  logic wr_reload_a;
  logic wr_reload_b;
  logic [3:0] pend_set;
  logic [3:0] pend_clear;
  logic [3:0] effective_enable;

  always_comb
  begin
    mode_cap2 = (q.mode_select == MODE_DUAL_CAPTURE);
    mode_cap4 = (q.mode_select == MODE_SINGLE_CAPTURE);
    capture_mode = mode_cap2 || mode_cap4;
    change_a = settled_change(q.sync_a, q.stable_a);
    change_b = settled_change(q.sync_b, q.stable_b);
    change_slow = settled_change(q.sync_slow, q.stable_slow);
    // Polarity bit low selects rising edges, high selects falling edges.
    edge_event_a = change_a && (q.sync_a[2] != q.edge_a);
    edge_event_b = change_b && (q.sync_b[2] != q.edge_b);
    prescaled_tick = (q.prescale_count == 5'h00);
    tick_one = count_tick(q.clock_one, capture_mode, prescaled_tick, edge_event_b,
                          q.stable_b != q.edge_b, change_slow && q.sync_slow[2]);
    tick_two = count_tick(q.clock_two, capture_mode, prescaled_tick, edge_event_b,
                          q.stable_b != q.edge_b, change_slow && q.sync_slow[2]);
    underflow_one = tick_one && (q.counter_one == 16'h0000);
    underflow_two = tick_two && (q.counter_two == 16'h0000);
    capture_a = mode_cap2 && edge_event_a;
    capture_b = capture_mode && edge_event_b;
    write_access = ce && psel && penable && pwrite && addr_mapped(paddr);
    setup_access = ce && psel && !penable;
    wr_counter_one = write_access && (paddr == ADDR_COUNTER_ONE);
    wr_counter_two = write_access && (paddr == ADDR_COUNTER_TWO);
    wr_reload_a = write_access && (paddr == ADDR_RELOAD_CAPTURE_A);
    wr_reload_b = write_access && (paddr == ADDR_RELOAD_CAPTURE_B);
    pend_set = 4'h0;
    pend_set[SRC_A] = capture_a;
    pend_set[SRC_B] = capture_b;
    pend_set[SRC_C] = mode_cap2 ? underflow_one
                                : (underflow_one && q.pin_a_output_enable && !q.pin_a_level);
    pend_set[SRC_D] = underflow_two;
    pend_clear = 4'h0;
    if (write_access && (paddr == ADDR_INT_CLEAR))
      pend_clear = pwdata[3:0];
    effective_enable = q.int_enable;
    // Outside dual-capture the pin A toggle event is gated by the A enable.
    effective_enable[SRC_C] = mode_cap2 ? q.int_enable[SRC_C] : q.int_enable[SRC_A];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    next_q = q;
    if (ce)
    begin
      next_q.sync_a = {q.sync_a[1:0], timer_io_a_in};
      next_q.sync_b = {q.sync_b[1:0], timer_io_b_in};
      next_q.sync_slow = {q.sync_slow[1:0], slow_clock_in};
      if (q.sync_a[1] == q.sync_a[2])
        next_q.stable_a = q.sync_a[2];
      if (q.sync_b[1] == q.sync_b[2])
        next_q.stable_b = q.sync_b[2];
      if (q.sync_slow[1] == q.sync_slow[2])
        next_q.stable_slow = q.sync_slow[2];
      next_q.prescale_count = prescaled_tick ? q.prescale : q.prescale_count - 5'h01;

      // Counter one: dual-capture wraps, other modes reload from capture A.
      if (tick_one)
      begin
        next_q.counter_one = (underflow_one && !mode_cap2) ? q.reload_capture_a
                                                           : q.counter_one - 16'h0001;
      end
      if (capture_a)
      begin
        next_q.reload_capture_a = q.counter_one;
        if (q.pin_a_output_enable)
          next_q.counter_one = PRESET_VALUE;
      end
      if (capture_b && mode_cap2)
      begin
        next_q.reload_capture_b = q.counter_one;
        if (q.preset_b)
          next_q.counter_one = PRESET_VALUE;
      end

      // Counter two: dual-timer reloads from capture B, other modes wrap.
      if (tick_two)
      begin
        next_q.counter_two = (underflow_two && (q.mode_select == MODE_DUAL_TIMER)) ? q.reload_capture_b
                                                                                   : q.counter_two - 16'h0001;
      end
      if (capture_b && mode_cap4)
      begin
        next_q.reload_capture_b = q.counter_two;
        if (q.preset_b)
          next_q.counter_two = PRESET_VALUE;
      end

      // Pin A holds its initial level while counter one is stopped.
      if (q.clock_one == CLK_STOPPED)
        next_q.pin_a_level = q.pin_a_initial_level;
      else if (underflow_one && q.pin_a_output_enable && !mode_cap2)
        next_q.pin_a_level = !q.pin_a_level;

      // A new event wins over a clear in the same cycle.
      next_q.pending = (q.pending & ~pend_clear) | pend_set;

      // Software writes take effect at the end of the access phase.
      if (write_access)
      begin
        unique case (paddr)
          ADDR_PRESCALE: next_q.prescale = pwdata[4:0];
          ADDR_CLOCK_CONTROL:
          begin
            next_q.clock_one = pwdata[CLOCK_ONE_LSB +: 3];
            next_q.clock_two = pwdata[CLOCK_TWO_LSB +: 3];
          end
          ADDR_MODE_CONTROL:
          begin
            next_q.mode_select = pwdata[MODE_LSB +: 2];
            next_q.edge_a = pwdata[EDGE_A_BIT];
            next_q.edge_b = pwdata[EDGE_B_BIT];
            next_q.pin_a_output_enable = pwdata[PIN_A_ENABLE_BIT];
            next_q.preset_b = pwdata[PRESET_B_BIT];
            next_q.pin_a_initial_level = pwdata[PIN_A_LEVEL_BIT];
          end
          ADDR_INT_CONTROL: next_q.int_enable = pwdata[INT_ENABLE_LSB +: 4];
          default:
          begin
          end
        endcase
      end
      if (wr_counter_one)
        next_q.counter_one = pwdata[15:0];
      if (wr_counter_two)
        next_q.counter_two = pwdata[15:0];
      if (wr_reload_a)
        next_q.reload_capture_a = pwdata[15:0];
      if (wr_reload_b)
        next_q.reload_capture_b = pwdata[15:0];

      // Read data is taken in the setup cycle and presented in the access phase.
      if (setup_access)
      begin
        unique case (paddr)
          ADDR_PRESCALE: next_q.read_data = {27'h0, q.prescale};
          ADDR_CLOCK_CONTROL: next_q.read_data = {26'h0, q.clock_two, q.clock_one};
          ADDR_COUNTER_ONE: next_q.read_data = {16'h0, q.counter_one};
          ADDR_COUNTER_TWO: next_q.read_data = {16'h0, q.counter_two};
          ADDR_RELOAD_CAPTURE_A: next_q.read_data = {16'h0, q.reload_capture_a};
          ADDR_RELOAD_CAPTURE_B: next_q.read_data = {16'h0, q.reload_capture_b};
          ADDR_MODE_CONTROL: next_q.read_data = {25'h0, q.pin_a_initial_level, q.preset_b,
                                                 q.pin_a_output_enable, q.edge_b, q.edge_a, q.mode_select};
          ADDR_INT_CONTROL: next_q.read_data = {24'h0, q.pending, q.int_enable};
          default: next_q.read_data = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.prescale <= PRESCALE_RESET;
      q.prescale_count <= PRESCALE_RESET;
      q.counter_one <= COUNT_RESET;
      q.counter_two <= COUNT_RESET;
      q.clock_one <= CLK_STOPPED;
      q.clock_two <= CLK_STOPPED;
      q.mode_select <= MODE_PWM_TIMER;
      q.int_enable <= INT_RESET;
      q.pending <= INT_RESET;
    end
    else
    begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata = q.read_data;
  assign pready = ce;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign timer_io_a_out = q.pin_a_level;
  assign timer_io_a_oe = q.pin_a_output_enable && !mode_cap2;
  assign irq_line_14 = |(q.pending[SRC_C:SRC_A] & effective_enable[SRC_C:SRC_A]);
  assign irq_line_13 = q.pending[SRC_D] && q.int_enable[SRC_D];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_capture_a_copy: assert property (capture_a && ce && !wr_reload_a |=>
    q.reload_capture_a == $past(q.counter_one) && q.pending[SRC_A])
    else $error("capture A did not copy counter one");
  a_preset_one: assert property (capture_a && ce && q.pin_a_output_enable && !wr_counter_one |=>
    q.counter_one == 16'hffff)
    else $error("counter one was not preset after capture");
  a_capture_stop: assert property (capture_mode && (q.clock_one == CLK_EXT_EVENT ||
    q.clock_one == CLK_PULSE_ACC) && !write_access && !(capture_a && q.pin_a_output_enable) &&
    !(capture_b && q.preset_b) |=> q.counter_one == $past(q.counter_one))
    else $error("counter one ran on a forbidden clock in capture mode");
  a_reload_one: assert property (ce && underflow_one && !mode_cap2 && !wr_counter_one && !capture_a |=>
    q.counter_one == $past(q.reload_capture_a))
    else $error("counter one did not reload from capture A");
  a_reload_two: assert property (ce && underflow_two && q.mode_select == MODE_DUAL_TIMER && !wr_counter_two |=>
    q.counter_two == $past(q.reload_capture_b) && q.pending[SRC_D])
    else $error("counter two did not reload and pend");
  a_pin_toggle: assert property (ce && underflow_one && q.pin_a_output_enable && !mode_cap2 &&
    !write_access |=> q.pin_a_level != $past(q.pin_a_level))
    else $error("pin A did not toggle on underflow");
  a_rise_pend_c: assert property (ce && !mode_cap2 && underflow_one && q.pin_a_output_enable &&
    !q.pin_a_level && q.int_enable[SRC_A] && !write_access |=> q.pending[SRC_C] ##0 irq_line_14)
    else $error("pin A rise did not pend source C");
  a_capture_b_two: assert property (capture_b && mode_cap4 && ce && q.preset_b && !write_access |=>
    q.reload_capture_b == $past(q.counter_two) && q.counter_two == 16'hffff)
    else $error("single capture did not copy and preset counter two");
  a_pend_hold: assert property (q.pending[SRC_D] && !pend_clear[SRC_D] |=> q.pending[SRC_D])
    else $error("pending D dropped without a clear");
  a_irq_two: assert property (q.pending[SRC_D] && q.int_enable[SRC_D] |-> irq_line_13 &&
    (!irq_line_14 || q.pending[SRC_C:SRC_A] != 3'h0))
    else $error("interrupt two does not follow source D");

  c_capture_preset: cover property (capture_a && q.pin_a_output_enable ##1 q.counter_one == 16'hffff);
  c_reload_dual: cover property (underflow_two && q.mode_select == MODE_DUAL_TIMER);
  c_irq_one: cover property (!irq_line_14 ##1 irq_line_14);

endmodule

`default_nettype wire

// ---- sim/pin_source.sv ----
`timescale 1ns/1ps
`default_nettype none

// Outside signal source on the two timer pins; pins rest low.
module pin_source
(
  input wire logic clk,
  output logic pin_a,
  output logic pin_b
);
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // Changes one pin after an edge, then holds it eight cycles so the synchroniser sees it.
  task automatic drive(input logic sel_b, input logic level);
    @(posedge clk);
    if (sel_b)
      pin_b <= level;
    else
      pin_a <= level;
    repeat (8) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import timer_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, a_out, a_oe, a_src, b_src, a_wire, irq14, irq13, err;
  logic [15:0] v, r1, r2;
  int failures = 0;
  int num_checks = 0;
  int n;

  always #5 clk = ~clk;
  // The pin carries the device level while it drives, otherwise the outside source.
  assign a_wire = a_oe ? a_out : a_src;

  dual_counter_capture_timer i_dual_counter_capture_timer (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_io_a_in(a_wire), .timer_io_a_out(a_out), .timer_io_a_oe(a_oe),
    .timer_io_b_in(b_src), .slow_clock_in(1'b0), .irq_line_14(irq14), .irq_line_13(irq13));
  pin_source i_pin_source (.clk(clk), .pin_a(a_src), .pin_b(b_src));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      stop_test();
    end
    else
    begin
      // Let one more edge pass and settle mid-cycle, so levels read next show the transfer's effect.
      @(posedge clk);
      @(negedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, exp);
  endtask

  // Counts cycles until pin A changes level.
  task automatic gap(output int c);
    logic p;
    p = a_out;
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (a_out === p && c < 100);
    if (a_out === p)
    begin
      failures++;
      stop_test();
    end
  endtask

  // Pin A half period in system clocks with a prescaler divisor of one: reload value down to zero.
  function automatic logic [31:0] half_period(input logic [15:0] reload);
    return 32'(reload) + 32'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    v = 16'($urandom(26127));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i <= 8; i++)
      rdc(8'(4 * i), 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk_pin(err, 1'b1);
    // Dual timer: both counters reload, pin A toggles every r1 plus one cycles.
    r1 = 16'(3 + $urandom % 6);
    r2 = 16'(2 + $urandom % 4);
    wr(ADDR_RELOAD_CAPTURE_A, 32'(r1));
    wr(ADDR_COUNTER_ONE, 32'(r1));
    wr(ADDR_RELOAD_CAPTURE_B, 32'(r2));
    wr(ADDR_COUNTER_TWO, 32'(r2));
    wr(ADDR_INT_CONTROL, 32'h1);
    for (int lvl = 1; lvl >= 0; lvl--)
    begin
      wr(ADDR_MODE_CONTROL, 32'(MODE_DUAL_TIMER) | 32'h10 | (32'(lvl) << PIN_A_LEVEL_BIT));
      chk_pin(a_out, 1'(lvl));
      chk_pin(a_oe, 1'b1);
    end
    wr(ADDR_CLOCK_CONTROL, 32'({CLK_PRESCALED, CLK_PRESCALED}));
    gap(n);
    repeat (3)
    begin
      gap(n);
      chk_reg(32'(n), half_period(r1));
    end
    apb(1'b0, ADDR_INT_CONTROL, 32'h0);
    chk_reg(rd & 32'he0, 32'hc0);
    chk_pin(irq14, 1'b1);
    chk_pin(irq13, 1'b0);
    wr(ADDR_INT_CONTROL, 32'h9);
    chk_pin(irq13, 1'b1);
    wr(ADDR_CLOCK_CONTROL, 32'h0);
    wr(ADDR_INT_CLEAR, 32'hf);
    rdc(ADDR_INT_CONTROL, 32'h9);
    chk_pin(irq14, 1'b0);
    // Dual capture with a stopped counter: A rising with preset, B falling only.
    wr(ADDR_INT_CONTROL, 32'h0);
    wr(ADDR_COUNTER_ONE, 32'(v));
    wr(ADDR_MODE_CONTROL, 32'(MODE_DUAL_CAPTURE) | 32'h18);
    chk_pin(a_oe, 1'b0);
    i_pin_source.drive(1'b0, 1'b1);
    rdc(ADDR_RELOAD_CAPTURE_A, 32'(v));
    rdc(ADDR_COUNTER_ONE, 32'hffff);
    rdc(ADDR_INT_CONTROL, 32'h10);
    chk_pin(irq14, 1'b0);
    wr(ADDR_INT_CONTROL, 32'h1);
    chk_pin(irq14, 1'b1);
    i_pin_source.drive(1'b1, 1'b1);
    rdc(ADDR_INT_CONTROL, 32'h11);
    i_pin_source.drive(1'b1, 1'b0);
    rdc(ADDR_RELOAD_CAPTURE_B, 32'hffff);
    rdc(ADDR_INT_CONTROL, 32'h31);
    for (int j = 0; j < 2; j++)
    begin
      wr(ADDR_CLOCK_CONTROL, 32'(j == 0 ? {CLK_EXT_EVENT, CLK_EXT_EVENT} : {CLK_PULSE_ACC, CLK_PULSE_ACC}));
      wr(ADDR_COUNTER_ONE, 32'(v));
      i_pin_source.drive(1'b1, 1'b1);
      i_pin_source.drive(1'b1, 1'b0);
      rdc(ADDR_COUNTER_ONE, 32'(v));
    end
    wr(ADDR_CLOCK_CONTROL, 32'h0);
    wr(ADDR_INT_CLEAR, 32'hf);
    // Single capture: counter two kept on a selected clock, B rising with preset.
    v = 16'($urandom);
    wr(ADDR_COUNTER_TWO, 32'(v));
    wr(ADDR_CLOCK_CONTROL, 32'(CLK_SLOW) << CLOCK_TWO_LSB);
    wr(ADDR_MODE_CONTROL, 32'(MODE_SINGLE_CAPTURE) | 32'h20);
    wr(ADDR_INT_CONTROL, 32'h2);
    i_pin_source.drive(1'b1, 1'b1);
    rdc(ADDR_RELOAD_CAPTURE_B, 32'(v));
    rdc(ADDR_COUNTER_TWO, 32'hffff);
    rdc(ADDR_INT_CONTROL, 32'h22);
    chk_pin(irq14, 1'b1);
    chk_pin(irq13, 1'b0);
    stop_test();
  end
endmodule

`default_nettype wire
